// ==== design/spi_paged_pkg.sv ====
package spi_paged_pkg;

   // ************************************************
   // command byte layout
   // ************************************************
   localparam int CMD_RW_BIT = 7;
   localparam int CMD_ID_MSB = 6;
   localparam int CMD_ID_LSB = 4;
   localparam int CMD_PAGE_MSB = 3;
   localparam int CMD_PAGE_LSB = 0;
   localparam logic CMD_RW_WRITE = 1'b0;
   localparam logic CMD_RW_READ = 1'b1;

   // page numbers
   localparam logic [3:0] PAGE_LED_DUTY = 4'h0;
   localparam logic [3:0] PAGE_LED_SCALE = 4'h1;

   // chip identifier, value is arbitrary
   localparam logic [2:0] CHIP_ID_DEFAULT = 3'h5;

   // ************************************************
   // serial framing and reset values
   // ************************************************
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] ADDR_STEP = 8'h01;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // write word: page bit, address, data
   localparam int WR_WORD_W = 1 + 2 * BYTE_BITS;
   localparam int WR_BUF_DEPTH = 2;

   // ************************************************
   // timing
   // ************************************************
   localparam int CORE_CLK_HZ = 40_000_000;
   localparam int SCK_MAX_MHZ = 12;
   // shortest serial clock period in core cycles, rounded down
   localparam int SCK_MIN_PERIOD_CYC = CORE_CLK_HZ / (SCK_MAX_MHZ * 1_000_000);

   typedef enum logic [1:0] {
      ST_CMD,
      ST_ADDR,
      ST_DATA,
      ST_IGNORE
   } xfer_state_e;

endpackage

// ==== design/serial_byte_rx.sv ====
module serial_byte_rx
   import spi_paged_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_clear,
   input wire logic i_sample,
   input wire logic i_bit,
   output logic o_byte_done,
   output logic [7:0] o_byte
);

   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic [6:0] sr_q;
   logic [6:0] sr_d;

   // ************************************************
   // bit counter and shift register
   // ************************************************
   // byte completes on the eighth sampled bit, msb first
   assign o_byte_done = i_sample && (cnt_q == BIT_CNT_LAST);
   assign o_byte = {sr_q, i_bit};

   // next count and shift value
   always_comb begin
      cnt_d = cnt_q;
      sr_d = sr_q;
      if (i_clear) begin
         cnt_d = BIT_CNT_RESET;
      end else if (i_sample) begin
         cnt_d = cnt_q + 3'h1;
         sr_d = {sr_q[5:0], i_bit};
      end
   end

   // register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         cnt_q <= BIT_CNT_RESET;
         sr_q <= 7'h00;
      end else begin
         cnt_q <= cnt_d;
         sr_q <= sr_d;
      end
   end

endmodule // serial_byte_rx

// ==== design/pair_buffer.sv ====
module pair_buffer
   import spi_paged_pkg::*;
#(
   parameter int WIDTH = WR_WORD_W
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   logic [WIDTH-1:0] mem_q [WR_BUF_DEPTH];
   logic [WIDTH-1:0] mem_d [WR_BUF_DEPTH];
   logic wp_q, wp_d, rp_q, rp_d;
   logic [1:0] cnt_q, cnt_d;
   logic push, pop;

   // ************************************************
   // flags and pointers
   // ************************************************
   assign o_in_ready = (cnt_q != 2'h2);
   assign o_out_valid = (cnt_q != 2'h0);
   assign o_out_data = mem_q[rp_q];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // pointer and fill count update
   always_comb begin
      wp_d = push ? ~wp_q : wp_q;
      rp_d = pop ? ~rp_q : rp_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   // per entry storage write
   for (genvar e = 0; e < WR_BUF_DEPTH; e++) begin : g_entry
      always_comb begin
         mem_d[e] = mem_q[e];
         if (push && (wp_q == 1'(e))) begin
            mem_d[e] = i_in_data;
         end
      end

      always_ff @(posedge i_core_clk) begin
         if (!i_resetn) begin
            mem_q[e] <= '0;
         end else begin
            mem_q[e] <= mem_d[e];
         end
      end
   end

   // register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

endmodule // pair_buffer

// ==== design/spi_paged_register_access.sv ====
module spi_paged_register_access
   import spi_paged_pkg::*;
#(
   parameter logic [2:0] CHIP_ID = CHIP_ID_DEFAULT
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_shutdown_input_n,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_mosi,
   output logic o_miso,
   output logic o_miso_oe_n,
   output logic o_rd_en,
   output logic o_rd_page,
   output logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   output logic o_wr_page,
   output logic [7:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic o_wr_overflow,
   output logic o_busy
);

   // ************************************************
   // declarations
   // ************************************************
   // edge history
   logic sck_q, sck_d;
   logic sdb_q, sdb_d;
   logic sck_rise, sck_fall, sdb_rise, clear;

   // sequencer, miso shifter and overflow flag state
   xfer_state_e state_q, state_d;
   logic rw_q, rw_d;
   logic page_q, page_d;
   logic [7:0] addr_q, addr_d;
   logic [7:0] tx_q, tx_d;
   logic fresh_q, fresh_d;
   logic drive_q, drive_d;
   logic ovf_q, ovf_d;

   // receiver, decode and buffer links
   logic byte_done;
   logic [7:0] rx_byte;
   logic cmd_ok;
   logic cmd_rw;
   logic [2:0] cmd_id;
   logic [3:0] cmd_page;
   logic load;
   logic push;
   logic buf_in_ready;
   logic [WR_WORD_W-1:0] buf_out;

   // ************************************************
   // edge detection
   // ************************************************
   // previous levels of serial clock and shutdown pin
   always_comb begin
      sck_d = i_sck;
      sdb_d = i_shutdown_input_n;
   end

   // history resets to the idle level of each pin
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sck_q <= 1'b0;
         sdb_q <= 1'b1;
      end else begin
         sck_q <= sck_d;
         sdb_q <= sdb_d;
      end
   end

   assign sck_rise = i_sck && !sck_q && !i_cs_n;
   // falling edge moves the next miso bit
   assign sck_fall = !i_sck && sck_q && !i_cs_n;
   assign sdb_rise = i_shutdown_input_n && !sdb_q;
   assign clear = i_cs_n || sdb_rise;

   // ************************************************
   // byte receiver
   // ************************************************
   // counter restarts on deselect or shutdown release
   // eight bit units
   serial_byte_rx u_rx (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_clear(clear),
      .i_sample(sck_rise),
      .i_bit(i_mosi),
      .o_byte_done(byte_done),
      .o_byte(rx_byte)
   );

   // ************************************************
   // command decode
   // ************************************************
   // command fields
   assign cmd_rw = rx_byte[CMD_RW_BIT];
   assign cmd_id = rx_byte[CMD_ID_MSB:CMD_ID_LSB];
   assign cmd_page = rx_byte[CMD_PAGE_MSB:CMD_PAGE_LSB];
   assign cmd_ok = (cmd_id == CHIP_ID)
      && ((cmd_page == PAGE_LED_DUTY)
      || (cmd_page == PAGE_LED_SCALE));

   // ************************************************
   // transfer sequencer
   // ************************************************
   // next state, pointer, read and write strobes
   always_comb begin
      state_d = state_q;
      rw_d = rw_q;
      page_d = page_q;
      addr_d = addr_q;
      load = 1'b0;
      push = 1'b0;
      if (clear) begin
         state_d = ST_CMD;
      end else if (byte_done) begin
         case (state_q)
            ST_CMD: begin
               if (cmd_ok) begin
                  rw_d = cmd_rw;
                  page_d = (cmd_page == PAGE_LED_SCALE);
                  state_d = ST_ADDR;
               end else begin
                  state_d = ST_IGNORE;
               end
            end
            ST_ADDR: begin
               addr_d = rx_byte;
               state_d = ST_DATA;
               if (rw_q == CMD_RW_READ) begin
                  load = 1'b1;
               end
            end
            ST_DATA: begin
               addr_d = addr_q + ADDR_STEP;
               if (rw_q == CMD_RW_WRITE) begin
                  push = 1'b1;
               end else begin
                  load = 1'b1;
               end
            end
            ST_IGNORE: begin
               state_d = ST_IGNORE;
            end
            default: begin
               state_d = ST_CMD;
            end
         endcase
      end
   end

   // sequencer register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         state_q <= ST_CMD;
         rw_q <= CMD_RW_WRITE;
         page_q <= 1'b0;
         addr_q <= ADDR_RESET;
      end else begin
         state_q <= state_d;
         rw_q <= rw_d;
         page_q <= page_d;
         addr_q <= addr_d;
      end
   end

   // ************************************************
   // miso shift register
   // ************************************************
   // load on a read strobe, shift on later falling edges
   always_comb begin
      tx_d = tx_q;
      fresh_d = fresh_q;
      drive_d = drive_q;
      if (clear) begin
         drive_d = 1'b0;
         fresh_d = 1'b0;
      end else if (load) begin
         tx_d = i_rd_data;
         fresh_d = 1'b1;
         drive_d = 1'b1;
      end else if (sck_fall && drive_q) begin
         // first falling edge after a load keeps bit 7 on the line
         if (fresh_q) begin
            fresh_d = 1'b0;
         end else begin
            tx_d = {tx_q[6:0], 1'b0};
         end
      end
   end

   // shifter register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         tx_q <= BYTE_RESET;
         fresh_q <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         tx_q <= tx_d;
         fresh_q <= fresh_d;
         drive_q <= drive_d;
      end
   end

   // ************************************************
   // write overflow flag
   // ************************************************
   // pulse when the write buffer cannot take a byte
   always_comb begin
      ovf_d = push && !buf_in_ready;
   end

   // overflow register stage
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= ovf_d;
      end
   end

   // ************************************************
   // register core read port
   // ************************************************
   // either page readable
   assign o_rd_en = load;
   assign o_rd_page = page_q;
   // next pointer, so the loaded byte matches the strobe
   assign o_rd_addr = addr_d;

   // ************************************************
   // miso pin
   // ************************************************
   // undriven unless reading
   assign o_miso = tx_q[7];
   // enable low while the shifter drives
   assign o_miso_oe_n = !drive_q;

   // ************************************************
   // write path buffer
   // ************************************************
   // page and address kept with data
   pair_buffer #(
      .WIDTH(WR_WORD_W)
   ) u_wbuf (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_in_valid(push),
      .o_in_ready(buf_in_ready),
      .i_in_data({page_q, addr_q, rx_byte}),
      .o_out_valid(o_wr_valid),
      .i_out_ready(i_wr_ready),
      .o_out_data(buf_out)
   );

   // head entry of the write buffer
   assign o_wr_page = buf_out[WR_WORD_W-1];
   assign o_wr_addr = buf_out[2*BYTE_BITS-1:BYTE_BITS];
   assign o_wr_data = buf_out[BYTE_BITS-1:0];
   assign o_wr_overflow = ovf_q;

   // busy from the command byte until deselect or shutdown release
   assign o_busy = (state_q != ST_CMD);

endmodule // spi_paged_register_access

// ==== verif/spi_paged_register_access_assertions.sv ====
// ************************************************
// port checker for the paged serial front end
// ************************************************
module spi_paged_chk
   import spi_paged_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_shutdown_input_n,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic o_miso,
   input wire logic o_miso_oe_n,
   input wire logic o_rd_en,
   input wire logic o_rd_page,
   input wire logic [7:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   input wire logic o_wr_valid,
   input wire logic i_wr_ready,
   input wire logic o_wr_page,
   input wire logic [7:0] o_wr_addr,
   input wire logic [7:0] o_wr_data,
   input wire logic o_wr_overflow,
   input wire logic o_busy
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   // deselect and shutdown release return to idle
   a_deselect_miso_off: assert property (i_cs_n |=> o_miso_oe_n)
      else $error("miso driven after deselect");
   a_deselect_idle: assert property (i_cs_n |=> !o_busy)
      else $error("busy after deselect");
   a_shutdown_clear: assert property ($rose(i_shutdown_input_n) |=> o_miso_oe_n && !o_busy)
      else $error("shutdown rise did not clear");
   // reads only on a selected rising serial edge
   a_read_on_rise: assert property (o_rd_en |-> !i_cs_n && i_sck && !$past(i_sck))
      else $error("read strobe off a rising edge");
   a_miso_after_read: assert property ($fell(o_miso_oe_n) |-> $past(o_rd_en))
      else $error("miso driven without a read");
   a_miso_steady: assert property (!i_cs_n && $stable(i_sck) && !o_rd_en && i_shutdown_input_n
      && $stable(i_shutdown_input_n) |=> $stable(o_miso))
      else $error("miso moved without a serial edge");
   // write buffer behaviour
   a_wr_from_rise: assert property ($rose(o_wr_valid) |-> $past(!i_cs_n && i_sck))
      else $error("write entry without a serial edge");
   a_wr_hold: assert property (o_wr_valid && !i_wr_ready
      |=> o_wr_valid && $stable({o_wr_page, o_wr_addr, o_wr_data}))
      else $error("stalled write entry changed");
   a_overflow_full: assert property (o_wr_overflow |-> $past(o_wr_valid))
      else $error("overflow with room left");

   // main scenarios reached
   c_read: cover property (o_rd_en);
   c_write: cover property (o_wr_valid && i_wr_ready);
   c_overflow: cover property (o_wr_overflow);
endmodule // spi_paged_chk

bind spi_paged_register_access spi_paged_chk u_chk (
   .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_shutdown_input_n(i_shutdown_input_n),
   .i_cs_n(i_cs_n), .i_sck(i_sck), .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n),
   .o_rd_en(o_rd_en), .o_rd_page(o_rd_page), .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data),
   .o_wr_valid(o_wr_valid), .i_wr_ready(i_wr_ready), .o_wr_page(o_wr_page), .o_wr_addr(o_wr_addr),
   .o_wr_data(o_wr_data), .o_wr_overflow(o_wr_overflow), .o_busy(o_busy));

// ==== verif/spi_master_model.sv ====
// ************************************************
// serial master driving the front end
// ************************************************
module spi_master_model (
   input wire logic i_clk,
   input wire logic i_miso,
   input wire logic i_miso_oe_n,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_mosi
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle lines at time zero
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_mosi = 1'b0;
   end

   task automatic open_frame();
      @(negedge i_clk);
      o_cs_n = 1'b0;
   endtask

   // clock low, then deselect
   task automatic close_frame();
      @(negedge i_clk);
      o_sck = 1'b0;
      @(negedge i_clk);
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi; // no stale bit left
   endtask

   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(negedge i_clk);
         o_sck = 1'b0;
         o_mosi = tx[i];
         repeat (2) @(negedge i_clk);
         o_sck = 1'b1;
         rx[i] = i_miso_oe_n ? 1'bz : i_miso; // undriven reads as z
         @(negedge i_clk);
      end
   endtask
endmodule // spi_master_model

// ==== verif/spi_paged_register_access_tb.sv ====
module spi_paged_register_access_tb
   import spi_paged_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic shutdown_n = 1'b1;
   logic wr_ready = 1'b1;
   logic cs_n, sck, mosi, miso, miso_oe_n, rd_en, rd_page, wr_valid, wr_page, wr_overflow, busy;
   logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
   logic [16:0] wr_log[$];
   logic [7:0] got_q[$];
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int ovf_n = 0;
   int rd_n = 0;

   // ************************************************
   // clock, register core, partner
   // ************************************************
   always #12.5 clk = ~clk;
   assign rd_data = rd_addr ^ 8'h5a ^ {7'h00, rd_page};

   // log accepted writes, drops and read strobes
   always @(posedge clk) begin
      if (wr_valid === 1'b1 && wr_ready) begin
         wr_log.push_back({wr_page, wr_addr, wr_data});
      end
      if (wr_overflow === 1'b1) begin
         ovf_n++;
      end
      if (rd_en === 1'b1) begin
         rd_n++;
      end
   end

   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         close_out();
      end
   end

   spi_master_model m (.i_clk(clk), .i_miso(miso), .i_miso_oe_n(miso_oe_n), .o_cs_n(cs_n),
      .o_sck(sck), .o_mosi(mosi));

   spi_paged_register_access dut (.i_core_clk(clk), .i_resetn(resetn), .i_shutdown_input_n(shutdown_n),
      .i_cs_n(cs_n), .i_sck(sck), .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
      .o_rd_en(rd_en), .o_rd_page(rd_page), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
      .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_page(wr_page), .o_wr_addr(wr_addr),
      .o_wr_data(wr_data), .o_wr_overflow(wr_overflow), .o_busy(busy));

   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic frame(input logic [7:0] cmd, input logic [7:0] addr, input int n, input logic [7:0] d0);
      logic [7:0] rx;
      got_q.delete();
      rd_n = 0;
      wr_log.delete();
      m.open_frame();
      m.shift_byte(cmd, rx);
      m.shift_byte(addr, rx);
      for (int i = 0; i < n; i++) begin
         m.shift_byte(d0 + 8'(i), rx);
         got_q.push_back(rx);
      end
      m.close_frame();
      repeat (3) @(negedge clk);
   endtask

   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ************************************************
   // scenarios
   // ************************************************
   task automatic t_write();
      for (int p = 0; p < 2; p++) begin
         frame({CMD_RW_WRITE, CHIP_ID_DEFAULT, 4'(p)}, 8'h47, 3, 8'hc1);
         chk(17'(wr_log.size()), 17'd3);
         chk(17'(rd_n), 17'd0);
         for (int i = 0; i < 3; i++) begin
            chk(wr_log[i], {1'(p), 8'h47 + 8'(i), 8'hc1 + 8'(i)});
         end
      end
   endtask

   task automatic t_read();
      for (int p = 0; p < 2; p++) begin
         frame({CMD_RW_READ, CHIP_ID_DEFAULT, 4'(p)}, 8'h4f, 3, 8'h00);
         chk(17'(wr_log.size()), 17'd0);
         chk(17'(rd_n), 17'd4);
         for (int i = 0; i < 3; i++) begin
            chk({9'h000, got_q[i]}, {9'h000, (8'h4f + 8'(i)) ^ 8'h5a ^ 8'(p)});
         end
      end
   endtask

   task automatic t_foreign();
      logic [7:0] cmds[3] = '{{1'b1, 3'h2, 4'h0}, {1'b1, CHIP_ID_DEFAULT, 4'h3}, {1'b0, 3'h2, 4'h1}};
      foreach (cmds[k]) begin
         frame(cmds[k], 8'h01, 2, 8'h11);
         chk({9'h000, got_q[0]}, {9'h000, 8'hzz});
         chk(17'(wr_log.size()), 17'd0);
         chk(17'(rd_n), 17'd0);
      end
   endtask

   task automatic t_stall();
      wr_ready = 1'b0;
      ovf_n = 0;
      frame({CMD_RW_WRITE, CHIP_ID_DEFAULT, PAGE_LED_DUTY}, 8'h20, 3, 8'h90);
      chk(17'(ovf_n), 17'd1);
      wr_ready = 1'b1;
      repeat (4) @(negedge clk);
      chk(17'(wr_log.size()), 17'd2);
      chk(wr_log[0], {1'b0, 8'h20, 8'h90});
      chk(wr_log[1], {1'b0, 8'h21, 8'h91});
   endtask

   task automatic t_shutdown();
      logic [7:0] rx;
      wr_log.delete();
      m.open_frame();
      m.shift_byte({CMD_RW_WRITE, CHIP_ID_DEFAULT, PAGE_LED_DUTY}, rx);
      chk({16'h0000, busy}, 17'h00001);
      @(negedge clk);
      shutdown_n = 1'b0;
      @(negedge clk);
      shutdown_n = 1'b1;
      @(negedge clk);
      chk({16'h0000, busy}, 17'h00000);
      m.shift_byte({CMD_RW_WRITE, CHIP_ID_DEFAULT, PAGE_LED_DUTY}, rx);
      m.shift_byte(8'h30, rx);
      m.shift_byte(8'h3c, rx);
      m.close_frame();
      repeat (3) @(negedge clk);
      chk(17'(wr_log.size()), 17'd1);
      chk(wr_log[0], {1'b0, 8'h30, 8'h3c});
   endtask

   // reset, then every scenario in turn
   initial begin
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      t_write();
      t_read();
      t_foreign();
      t_stall();
      t_shutdown();
      close_out();
   end
endmodule // spi_paged_register_access_tb
